// File: common/rest_cfg.svh
// Notes on behaviour
// - Harmonic summary zero without harmonic unit fitted
// - Harmonic summary bits 1-6, three at most
// - Harmonic bits summarise channel registers 9-14
// - Harmonic summary bits 7 and 0 read zero
// - Channel register: crest, power, current, voltage bits
// - Channel summaries feed input and harmonic summaries
// - Frequency register: C bit3, B bit2, A bit1
// - Masked frequency summary drives input summary bit0
// - Each event register has settable readable mask
// - Go-to-local leaves remote, enters local state, or local lockout state if locked out
// - Local lockout disables every key, local too
// - Device clears empty input buffer and output queue
// - Trigger while held gives one single shot
// - Summary is OR of masked event bits
// - Events cleared by clear, own read, power-on
// - Clear status keeps masks, queue, message bit
`ifndef REST_CFG_SVH
`define REST_CFG_SVH

// ----------------------------------------------------------------
// Field layouts
// ----------------------------------------------------------------
`define REST_NCH 6
`define REST_CH_USED 8'h37
`define REST_FREQ_USED 8'h0e
`define REST_IN_SUM_USED 8'h7f
`define REST_HARM_SUM_USED 8'h7e
`define REST_FREQ_OVER_BIT 0
`define REST_HARM_MAX 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define REST_EV_RESET 8'h00
`define REST_MASK_RESET 8'h00

// ----------------------------------------------------------------
// Register select codes
// ----------------------------------------------------------------
`define REST_SEL_IN_SUM 5'h00
`define REST_SEL_HARM_SUM 5'h01
`define REST_SEL_FREQ 5'h02
`define REST_SEL_CH_BASE 5'h03

`endif

// File: common/rest_pkg.sv
package rest_pkg;
  typedef logic [7:0] rest_byte_t;
  typedef logic [5:0][7:0] rest_bank_t;

  typedef enum logic [1:0] {
    REST_OP_READ_EVENT = 2'h0,
    REST_OP_WRITE_MASK = 2'h1,
    REST_OP_READ_MASK = 2'h2,
    REST_OP_CLEAR_STATUS = 2'h3
  } rest_op_e;

  typedef enum logic [3:0] {
    REST_ST_LOCAL = 4'b0001,
    REST_ST_REMOTE = 4'b0010,
    REST_ST_LOCK_REM = 4'b0100,
    REST_ST_LOCK_LOC = 4'b1000
  } rest_rstate_e;

  typedef struct packed {
    rest_byte_t ev;
    rest_byte_t mask;
  } rest_evreg_s;

  typedef struct packed {
    rest_rstate_e mode;
    logic flush;
    logic shot;
  } rest_msg_s;

  typedef struct packed {
    logic rsp_valid;
    rest_byte_t rsp_data;
  } rest_top_s;
endpackage

// File: common/rest_evreg_if.sv
interface rest_evreg_if;
  import rest_pkg::*;
  rest_byte_t set;
  rest_byte_t clr;
  logic wr_mask;
  rest_byte_t wdata;
  rest_byte_t ev;
  rest_byte_t mask;
  logic sum;
  modport owner (input set, input clr, input wr_mask, input wdata,
                 output ev, output mask, output sum);
  modport user (output set, output clr, output wr_mask, output wdata,
                input ev, input mask, input sum);
endinterface

// File: core/rest_evreg.sv
`include "rest_cfg.svh"
module rest_evreg #(
  parameter rest_pkg::rest_byte_t USED = `REST_CH_USED
) (
  input wire logic i_clk,
  input wire logic i_rst,
  rest_evreg_if.owner port
);
  import rest_pkg::*;

  rest_evreg_s st;
  rest_evreg_s next_st;
  rest_byte_t set_used;

  assign set_used = port.set & USED;

  // ----------------------------------------------------------------
  // Sticky event bits and mask
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.ev = ((st.ev & ~port.clr) | set_used) & USED;
    if (port.wr_mask) begin
      next_st.mask = port.wdata & USED;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '{ev: `REST_EV_RESET, mask: `REST_MASK_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign port.ev = st.ev;
  assign port.mask = st.mask;
  assign port.sum = |(st.ev & st.mask);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_set_lands: assert property (set_used != 8'h00 |=>
    (port.ev & $past(set_used)) == $past(set_used)) else $error("event set lost");
  a_sticky_hold: assert property (port.clr == 8'h00 |=>
    (port.ev & $past(port.ev)) == $past(port.ev)) else $error("event dropped");
  a_clear_empties: assert property ((port.clr == 8'hff && set_used == 8'h00)
    |=> port.ev == 8'h00) else $error("clear failed");
  a_unused_zero: assert property ((port.ev & ~USED) == 8'h00)
    else $error("unused bit set");
  a_mask_gates: assert property ((port.wr_mask && port.wdata == 8'h00)
    |=> !port.sum) else $error("masked summary set");
endmodule

// File: core/rest_msg.sv
`include "rest_cfg.svh"
module rest_msg (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ren,
  input wire logic i_addressed,
  input wire logic i_local_key,
  input wire logic i_msg_gtl,
  input wire logic i_msg_llo,
  input wire logic i_msg_dcl,
  input wire logic i_msg_sdc,
  input wire logic i_msg_get,
  input wire logic i_hold,
  output logic o_remote,
  output logic o_panel_keys_en,
  output logic o_local_key_en,
  output logic o_flush,
  output logic o_single_shot
);
  import rest_pkg::*;

  rest_msg_s st;
  rest_msg_s next_st;

  // ----------------------------------------------------------------
  // Remote / local state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.flush = i_msg_dcl | i_msg_sdc;
    next_st.shot = i_msg_get & i_hold;
    case (st.mode)
      REST_ST_LOCAL: begin
        if (i_msg_llo) begin
          next_st.mode = REST_ST_LOCK_LOC;
        end else if (i_ren && i_addressed && !i_msg_gtl) begin
          next_st.mode = REST_ST_REMOTE;
        end
      end
      REST_ST_REMOTE: begin
        if (i_msg_llo) begin
          next_st.mode = i_msg_gtl ? REST_ST_LOCK_LOC : REST_ST_LOCK_REM;
        end else if (i_msg_gtl || i_local_key) begin
          next_st.mode = REST_ST_LOCAL;
        end
      end
      REST_ST_LOCK_REM: begin
        if (i_msg_gtl) begin
          next_st.mode = REST_ST_LOCK_LOC;
        end
      end
      REST_ST_LOCK_LOC: begin
        if (i_ren && i_addressed && !i_msg_gtl) begin
          next_st.mode = REST_ST_LOCK_REM;
        end
      end
      default: begin
        next_st.mode = REST_ST_LOCAL;
      end
    endcase
    // Lockout only ends when remote enable drops
    if (!i_ren) begin
      next_st.mode = REST_ST_LOCAL;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '{mode: REST_ST_LOCAL, flush: 1'b0, shot: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign o_remote = (st.mode == REST_ST_REMOTE) || (st.mode == REST_ST_LOCK_REM);
  assign o_panel_keys_en = (st.mode == REST_ST_LOCAL);
  assign o_local_key_en = (st.mode == REST_ST_REMOTE);
  assign o_flush = st.flush;
  assign o_single_shot = st.shot;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_gtl_local: assert property (i_msg_gtl |=> !o_remote)
    else $error("still remote after go-to-local");
  a_llo_lock: assert property ((i_msg_llo && i_ren) |=>
    (!o_panel_keys_en && !o_local_key_en)) else $error("keys live after lockout");
  a_clear_flush: assert property ((i_msg_dcl || i_msg_sdc) |=> o_flush)
    else $error("no flush on device clear");
  a_get_single: assert property ((i_msg_get && i_hold && !$past(i_msg_get)) |=>
    o_single_shot ##1 (!o_single_shot || $past(i_msg_get)))
    else $error("trigger shot not single");
  c_lockout: cover property (o_remote && !o_local_key_en);
  c_shot: cover property (o_single_shot);
endmodule

// File: core/rest_top.sv
`include "rest_cfg.svh"
module rest_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  input wire rest_pkg::rest_op_e i_cmd_op,
  input wire logic [4:0] i_cmd_sel,
  input wire rest_pkg::rest_byte_t i_cmd_data,
  output logic o_rsp_valid,
  output rest_pkg::rest_byte_t o_rsp_data,
  input wire rest_pkg::rest_bank_t i_chan_fault,
  input wire rest_pkg::rest_bank_t i_harm_fault,
  input wire rest_pkg::rest_byte_t i_freq_fault,
  input wire logic i_harm_fitted,
  input wire logic [5:0] i_harm_sel,
  output logic o_stb_in_sum,
  output logic o_stb_harm_sum,
  input wire logic i_ren,
  input wire logic i_addressed,
  input wire logic i_local_key,
  input wire logic i_msg_gtl,
  input wire logic i_msg_llo,
  input wire logic i_msg_dcl,
  input wire logic i_msg_sdc,
  input wire logic i_msg_get,
  input wire logic i_hold,
  output logic o_remote,
  output logic o_panel_keys_en,
  output logic o_local_key_en,
  output logic o_flush_in,
  output logic o_flush_out,
  output logic o_single_shot
);
  import rest_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic sel_hit(input logic [4:0] sel, input logic [4:0] code);
    sel_hit = (sel == code);
  endfunction

  // Keeps the lowest selected boards so no more than three can report
  function automatic logic [5:0] keep_first(input logic [5:0] sel);
    logic [5:0] res;
    int n;
    res = 6'h00;
    n = 0;
    for (int k = 0; k < `REST_NCH; k++) begin
      if (sel[k] && n < `REST_HARM_MAX) begin
        res[k] = 1'b1;
        n = n + 1;
      end
    end
    keep_first = res;
  endfunction

  logic cmd_read;
  logic cmd_wmask;
  logic cmd_rmask;
  logic cmd_cls;
  logic [5:0] harm_keep;
  logic [5:0] ch_sum;
  logic [5:0] harm_sum;
  rest_top_s st;
  rest_top_s next_st;

  assign cmd_read = i_cmd_valid && (i_cmd_op == REST_OP_READ_EVENT);
  assign cmd_wmask = i_cmd_valid && (i_cmd_op == REST_OP_WRITE_MASK);
  assign cmd_rmask = i_cmd_valid && (i_cmd_op == REST_OP_READ_MASK);
  assign cmd_cls = i_cmd_valid && (i_cmd_op == REST_OP_CLEAR_STATUS);
  assign harm_keep = i_harm_fitted ? keep_first(i_harm_sel) : 6'h00;

  // ----------------------------------------------------------------
  // Channel registers: input units then harmonic boards
  // ----------------------------------------------------------------
  rest_evreg_if chan_if [0:11] ();
  rest_evreg_if freq_if ();
  rest_evreg_if in_sum_if ();
  rest_evreg_if harm_sum_if ();

  for (genvar g = 0; g < 2 * `REST_NCH; g++) begin : g_chan
    localparam logic [4:0] SEL = 5'(`REST_SEL_CH_BASE + g);
    rest_evreg #(
      .USED(`REST_CH_USED)
    ) u_chan (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .port(chan_if[g])
    );
    if (g < `REST_NCH) begin : g_in
      assign chan_if[g].set = i_chan_fault[g];
      assign ch_sum[g] = chan_if[g].sum;
    end else begin : g_harm
      // No harmonic faults without the unit
      assign chan_if[g].set = i_harm_fitted ? i_harm_fault[g - `REST_NCH] : 8'h00;
      assign harm_sum[g - `REST_NCH] = chan_if[g].sum;
    end
    // Clear by status clear or own read
    assign chan_if[g].clr = {8{cmd_cls || (cmd_read && sel_hit(i_cmd_sel, SEL))}};
    assign chan_if[g].wr_mask = cmd_wmask && sel_hit(i_cmd_sel, SEL);
    assign chan_if[g].wdata = i_cmd_data;
  end

  // ----------------------------------------------------------------
  // Frequency and summary registers
  // ----------------------------------------------------------------
  rest_evreg #(
    .USED(`REST_FREQ_USED)
  ) u_freq (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .port(freq_if)
  );
  assign freq_if.set = i_freq_fault;
  assign freq_if.clr = {8{cmd_cls || (cmd_read && sel_hit(i_cmd_sel, `REST_SEL_FREQ))}};
  assign freq_if.wr_mask = cmd_wmask && sel_hit(i_cmd_sel, `REST_SEL_FREQ);
  assign freq_if.wdata = i_cmd_data;

  rest_evreg #(
    .USED(`REST_IN_SUM_USED)
  ) u_in_sum (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .port(in_sum_if)
  );
  assign in_sum_if.set = {1'b0, ch_sum, freq_if.sum};
  assign in_sum_if.clr = {8{cmd_cls || (cmd_read && sel_hit(i_cmd_sel, `REST_SEL_IN_SUM))}};
  assign in_sum_if.wr_mask = cmd_wmask && sel_hit(i_cmd_sel, `REST_SEL_IN_SUM);
  assign in_sum_if.wdata = i_cmd_data;

  rest_evreg #(
    .USED(`REST_HARM_SUM_USED)
  ) u_harm_sum (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .port(harm_sum_if)
  );
  // Bits 7 and 0 never set
  assign harm_sum_if.set = {1'b0, harm_sum & harm_keep, 1'b0};
  // Stale bits of a dropped board would break the three-bit limit
  // Unselected or absent boards forced clear
  assign harm_sum_if.clr = {1'b1, ~harm_keep, 1'b1}
    | {8{cmd_cls || (cmd_read && sel_hit(i_cmd_sel, `REST_SEL_HARM_SUM))}};
  assign harm_sum_if.wr_mask = cmd_wmask && sel_hit(i_cmd_sel, `REST_SEL_HARM_SUM);
  assign harm_sum_if.wdata = i_cmd_data;

  // ----------------------------------------------------------------
  // Status byte
  // ----------------------------------------------------------------
  // Status byte summary bits
  assign o_stb_in_sum = in_sum_if.sum;
  assign o_stb_harm_sum = harm_sum_if.sum;

  // ----------------------------------------------------------------
  // Query answers
  // ----------------------------------------------------------------
  rest_byte_t rd_ev;
  rest_byte_t rd_mask;
  rest_byte_t ch_ev_mux [0:11];
  rest_byte_t ch_mask_mux [0:11];

  for (genvar r = 0; r < 2 * `REST_NCH; r++) begin : g_rd
    assign ch_ev_mux[r] = chan_if[r].ev;
    assign ch_mask_mux[r] = chan_if[r].mask;
  end

  always_comb begin
    rd_ev = 8'h00;
    rd_mask = 8'h00;
    if (sel_hit(i_cmd_sel, `REST_SEL_IN_SUM)) begin
      rd_ev = in_sum_if.ev;
      rd_mask = in_sum_if.mask;
    end else if (sel_hit(i_cmd_sel, `REST_SEL_HARM_SUM)) begin
      rd_ev = harm_sum_if.ev;
      rd_mask = harm_sum_if.mask;
    end else if (sel_hit(i_cmd_sel, `REST_SEL_FREQ)) begin
      rd_ev = freq_if.ev;
      rd_mask = freq_if.mask;
    end else begin
      for (int k = 0; k < 2 * `REST_NCH; k++) begin
        if (sel_hit(i_cmd_sel, 5'(`REST_SEL_CH_BASE + k))) begin
          rd_ev = ch_ev_mux[k];
          rd_mask = ch_mask_mux[k];
        end
      end
    end
  end

  always_comb begin
    next_st = st;
    next_st.rsp_valid = cmd_read || cmd_rmask;
    if (cmd_read) begin
      next_st.rsp_data = rd_ev;
    end else if (cmd_rmask) begin
      next_st.rsp_data = rd_mask;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '{rsp_valid: 1'b0, rsp_data: `REST_EV_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign o_rsp_valid = st.rsp_valid;
  assign o_rsp_data = st.rsp_data;

  // ----------------------------------------------------------------
  // Interface messages
  // ----------------------------------------------------------------
  logic flush;

  rest_msg u_msg (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ren(i_ren),
    .i_addressed(i_addressed),
    .i_local_key(i_local_key),
    .i_msg_gtl(i_msg_gtl),
    .i_msg_llo(i_msg_llo),
    .i_msg_dcl(i_msg_dcl),
    .i_msg_sdc(i_msg_sdc),
    .i_msg_get(i_msg_get),
    .i_hold(i_hold),
    .o_remote(o_remote),
    .o_panel_keys_en(o_panel_keys_en),
    .o_local_key_en(o_local_key_en),
    .o_flush(flush),
    .o_single_shot(o_single_shot)
  );

  // One pulse serves both, so neither side is flushed alone
  // Input buffer and output queue together
  assign o_flush_in = flush;
  assign o_flush_out = flush;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_harm_absent: assert property ((!i_harm_fitted && $past(!i_harm_fitted))
    |-> harm_sum_if.ev == 8'h00) else $error("harmonic summary set without unit");
  a_harm_three: assert property ($countones(harm_sum_if.ev) <= `REST_HARM_MAX)
    else $error("more than three harmonic bits");
  a_harm_feeds: assert property ((chan_if[6].sum && harm_keep[0])
    |=> harm_sum_if.ev[1]) else $error("harmonic channel summary lost");
  a_chan_feeds: assert property (chan_if[0].sum |=> in_sum_if.ev[1])
    else $error("channel summary lost");
  a_freq_feeds: assert property (freq_if.sum |=> in_sum_if.ev[`REST_FREQ_OVER_BIT])
    else $error("frequency summary lost");
  a_read_answers: assert property ((cmd_read || cmd_rmask) |=> o_rsp_valid ##1
    (!o_rsp_valid || $past(i_cmd_valid))) else $error("query answer timing");
  a_read_clears: assert property ((cmd_read && sel_hit(i_cmd_sel, `REST_SEL_FREQ)
    && i_freq_fault == 8'h00) |=> freq_if.ev == 8'h00) else $error("read did not clear");
  a_cls_keeps: assert property (cmd_cls |=>
    (freq_if.mask == $past(freq_if.mask) && in_sum_if.mask == $past(in_sum_if.mask)
     && o_flush_out == $past(i_msg_dcl || i_msg_sdc)))
    else $error("clear status disturbed masks or queue");
  a_write_silent: assert property ((cmd_wmask || cmd_cls) |=> !o_rsp_valid)
    else $error("answer to a command without reply");
  a_unmapped_zero: assert property ((cmd_read && i_cmd_sel == 5'h1f) |=>
    o_rsp_data == 8'h00) else $error("unmapped read not zero");

  // ----------------------------------------------------------------
  // Checks on fault layouts and message outputs
  // ----------------------------------------------------------------
  a_chan_bits: assert property (i_chan_fault[0][5] |=> chan_if[0].ev[5])
    else $error("current crest fault not latched");
  a_freq_bits: assert property (i_freq_fault[3] |=> freq_if.ev[3])
    else $error("frequency channel fault not latched");
  a_harm_edges: assert property (!harm_sum_if.ev[7] && !harm_sum_if.ev[0])
    else $error("unused harmonic summary bit set");
  a_flush_both: assert property ((i_msg_dcl || i_msg_sdc) |=>
    (o_flush_in && o_flush_out)) else $error("buffer and queue not flushed together");
  a_no_free_shot: assert property (!(i_msg_get && i_hold) |=> !o_single_shot)
    else $error("shot without held trigger");

  // Every channel, not only the first, must reach its summary bit
  for (genvar c = 0; c < `REST_NCH; c++) begin : g_chk
    a_in_feeds: assert property (chan_if[c].sum |=> in_sum_if.ev[c + 1])
      else $error("input channel summary lost");
    a_board_feeds: assert property ((chan_if[c + `REST_NCH].sum && harm_keep[c])
      |=> harm_sum_if.ev[c + 1]) else $error("harmonic board summary lost");
  end

  c_read_hit: cover property (cmd_read ##1 (o_rsp_data != 8'h00));
  c_stb_harm: cover property (o_stb_harm_sum);
  c_dev_clear: cover property (o_flush_in);
endmodule

// File: tb/rest_ctrl_model.sv
module rest_ctrl_model
  import rest_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rsp_valid,
  input wire rest_pkg::rest_byte_t i_rsp_data,
  output logic o_cmd_valid,
  output rest_pkg::rest_op_e o_cmd_op,
  output logic [4:0] o_cmd_sel,
  output rest_pkg::rest_byte_t o_cmd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import rest_pkg::*;

  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_op = REST_OP_READ_MASK;
    o_cmd_sel = 5'h1f;
    o_cmd_data = 8'ha5;
  end

  // Mask set, queries
  // Strobe lasts one cycle; gap gives a slow controller
  task automatic send(input int gap, input rest_op_e op, input logic [4:0] sel,
                      input rest_byte_t data, output rest_byte_t rsp, output logic got);
    repeat (gap + 1) @(negedge i_clk);
    o_cmd_valid = 1'b1;
    o_cmd_op = op;
    o_cmd_sel = sel;
    o_cmd_data = data;
    @(negedge i_clk);
    got = i_rsp_valid;
    rsp = i_rsp_data;
    o_cmd_valid = 1'b0;
    // Idle lines carry junk, never the last value
    o_cmd_op = rest_op_e'(~op);
    o_cmd_sel = ~sel;
    o_cmd_data = ~data;
  endtask
endmodule

// File: tb/rest_top_tb_top.sv
`include "rest_cfg.svh"
module rest_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rest_pkg::*;

  logic clk, rst, cmd_valid, rsp_valid, stb_in, stb_harm;
  rest_op_e cmd_op;
  logic [4:0] cmd_sel;
  rest_byte_t cmd_data, rsp_data, freq;
  rest_bank_t chan, harm;
  logic fitted, ren, addr_lvl, hold;
  logic [5:0] hsel;
  logic [6:0] msg;
  logic remote, keys_en, lkey_en, fl_in, fl_out, shot;
  int bad_count, n_compared, cyc;
  localparam logic [4:0] CH = `REST_SEL_CH_BASE;
  localparam logic [4:0] HC = `REST_SEL_CH_BASE + 5'h06;

  always #4 clk = ~clk;

  rest_ctrl_model i_host (.i_clk(clk), .i_rsp_valid(rsp_valid), .i_rsp_data(rsp_data),
    .o_cmd_valid(cmd_valid), .o_cmd_op(cmd_op), .o_cmd_sel(cmd_sel), .o_cmd_data(cmd_data));

  rest_top i_dut (.i_clk(clk), .i_rst(rst), .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op),
    .i_cmd_sel(cmd_sel), .i_cmd_data(cmd_data), .o_rsp_valid(rsp_valid),
    .o_rsp_data(rsp_data), .i_chan_fault(chan), .i_harm_fault(harm), .i_freq_fault(freq),
    .i_harm_fitted(fitted), .i_harm_sel(hsel), .o_stb_in_sum(stb_in),
    .o_stb_harm_sum(stb_harm), .i_ren(ren), .i_addressed(msg[5] | addr_lvl),
    .i_local_key(msg[6]), .i_msg_gtl(msg[0]), .i_msg_llo(msg[1]), .i_msg_dcl(msg[2]),
    .i_msg_sdc(msg[3]), .i_msg_get(msg[4]), .i_hold(hold), .o_remote(remote),
    .o_panel_keys_en(keys_en), .o_local_key_en(lkey_en), .o_flush_in(fl_in),
    .o_flush_out(fl_out), .o_single_shot(shot));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input rest_byte_t exp, input rest_byte_t got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic flag(input string nm, input logic exp, input logic got);
    chk(nm, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic rd(input rest_op_e op, input logic [4:0] sel, input rest_byte_t exp);
    rest_byte_t r;
    logic g;
    i_host.send(0, op, sel, 8'h00, r, g);
    flag("answer strobe", 1'b1, g);
    chk($sformatf("register %0d op %0d", sel, op), exp, r);
  endtask

  task automatic cmd(input rest_op_e op, input logic [4:0] sel, input rest_byte_t d);
    rest_byte_t r;
    logic g;
    i_host.send(1, op, sel, d, r, g);
    flag("silent command", 1'b0, g);
  endtask

  function automatic rest_bank_t one(input int k, input rest_byte_t v);
    one = '0;
    one[k] = v;
  endfunction

  // Faults last one cycle only, so anything read later proves stickiness
  task automatic hit(input rest_bank_t c, input rest_bank_t h, input rest_byte_t f);
    @(negedge clk);
    chan = c;
    harm = h;
    freq = f;
    @(negedge clk);
    chan = '0;
    harm = '0;
    freq = 8'h00;
    repeat (3) @(negedge clk);
  endtask

  task automatic pulse(input int k);
    @(negedge clk);
    msg[k] = 1'b1;
    @(negedge clk);
    msg[k] = 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Power-on clear
  task automatic t_reset();
    for (int s = 0; s < 15; s++) begin
      rd(REST_OP_READ_EVENT, 5'(s), `REST_EV_RESET);
      rd(REST_OP_READ_MASK, 5'(s), `REST_MASK_RESET);
    end
    rd(REST_OP_READ_EVENT, 5'h1f, 8'h00);
    flag("remote", 1'b0, remote);
    flag("panel keys", 1'b1, keys_en);
  endtask

  task automatic t_chan();
    for (int k = 0; k < `REST_NCH; k++) begin
      hit(one(k, 8'hff), '0, 8'h00);
      rd(REST_OP_READ_EVENT, CH + 5'(k), 8'h37);
      rd(REST_OP_READ_EVENT, CH + 5'(k), 8'h00);
      cmd(REST_OP_WRITE_MASK, CH + 5'(k), 8'hff);
      rd(REST_OP_READ_MASK, CH + 5'(k), 8'h37);
    end
  endtask

  task automatic t_sum();
    cmd(REST_OP_WRITE_MASK, CH + 5'h01, 8'h02);
    cmd(REST_OP_WRITE_MASK, CH + 5'h02, 8'h00);
    cmd(REST_OP_WRITE_MASK, `REST_SEL_IN_SUM, 8'h04);
    hit(one(1, 8'h02) | one(2, 8'h02), '0, 8'h00);
    flag("input summary out", 1'b1, stb_in);
    rd(REST_OP_READ_EVENT, CH + 5'h01, 8'h02);
    rd(REST_OP_READ_EVENT, CH + 5'h02, 8'h02);
    rd(REST_OP_READ_EVENT, `REST_SEL_IN_SUM, 8'h04);
    settle();
    flag("input summary out", 1'b0, stb_in);
  endtask

  task automatic t_freq();
    hit('0, '0, 8'hff);
    rd(REST_OP_READ_EVENT, `REST_SEL_FREQ, 8'h0e);
    cmd(REST_OP_WRITE_MASK, `REST_SEL_FREQ, 8'h02);
    cmd(REST_OP_WRITE_MASK, `REST_SEL_IN_SUM, 8'h01);
    hit('0, '0, 8'h02);
    flag("input summary out", 1'b1, stb_in);
    rd(REST_OP_READ_EVENT, `REST_SEL_FREQ, 8'h02);
    rd(REST_OP_READ_EVENT, `REST_SEL_IN_SUM, 8'h01);
    hit('0, '0, 8'h0c);
    rd(REST_OP_READ_EVENT, `REST_SEL_IN_SUM, 8'h00);
    rd(REST_OP_READ_EVENT, `REST_SEL_FREQ, 8'h0c);
  endtask

  task automatic t_harm();
    logic [5:0] lo3;
    lo3 = 6'h0d;
    fitted = 1'b1;
    hsel = 6'h2d;
    for (int k = 0; k < `REST_NCH; k++) begin
      cmd(REST_OP_WRITE_MASK, HC + 5'(k), 8'h01);
    end
    cmd(REST_OP_WRITE_MASK, `REST_SEL_HARM_SUM, 8'hff);
    rd(REST_OP_READ_MASK, `REST_SEL_HARM_SUM, 8'h7e);
    hit('0, {6{8'h01}}, 8'h00);
    flag("harmonic summary out", 1'b1, stb_harm);
    // Board registers latch alone; only the summary is limited to three
    for (int k = 0; k < `REST_NCH; k++) begin
      rd(REST_OP_READ_EVENT, HC + 5'(k), 8'h01);
    end
    rd(REST_OP_READ_EVENT, `REST_SEL_HARM_SUM, {1'b0, lo3, 1'b0});
    rd(REST_OP_READ_EVENT, `REST_SEL_HARM_SUM, 8'h00);
    fitted = 1'b0;
    hit('0, {6{8'hff}}, 8'h00);
    flag("harmonic summary out", 1'b0, stb_harm);
    rd(REST_OP_READ_EVENT, `REST_SEL_HARM_SUM, 8'h00);
    rd(REST_OP_READ_EVENT, HC, 8'h00);
  endtask

  task automatic t_clear();
    hit(one(0, 8'h01), '0, 8'h02);
    cmd(REST_OP_CLEAR_STATUS, 5'h00, 8'h00);
    flag("output flush", 1'b0, fl_out);
    rd(REST_OP_READ_EVENT, CH, 8'h00);
    rd(REST_OP_READ_EVENT, `REST_SEL_FREQ, 8'h00);
    rd(REST_OP_READ_MASK, CH, 8'h37);
    rd(REST_OP_READ_MASK, `REST_SEL_FREQ, 8'h02);
  endtask

  task automatic t_msg();
    ren = 1'b1;
    pulse(5);
    settle();
    flag("remote", 1'b1, remote);
    flag("local key", 1'b1, lkey_en);
    pulse(0);
    settle();
    flag("remote", 1'b0, remote);
    flag("panel keys", 1'b1, keys_en);
    pulse(5);
    pulse(1);
    settle();
    flag("panel keys", 1'b0, keys_en);
    flag("local key", 1'b0, lkey_en);
    pulse(6);
    settle();
    flag("remote", 1'b1, remote);
    pulse(0);
    settle();
    flag("remote", 1'b0, remote);
    flag("panel keys", 1'b0, keys_en);
    ren = 1'b0;
    settle();
    flag("panel keys", 1'b1, keys_en);
    addr_lvl = 1'b1;
    for (int k = 2; k < 4; k++) begin
      pulse(k);
      flag("input flush", 1'b1, fl_in);
      flag("output flush", 1'b1, fl_out);
      @(negedge clk);
      flag("output flush", 1'b0, fl_out);
    end
    addr_lvl = 1'b0;
    pulse(4);
    flag("single shot", 1'b0, shot);
    hold = 1'b1;
    pulse(4);
    flag("single shot", 1'b1, shot);
    @(negedge clk);
    flag("single shot", 1'b0, shot);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      end_of_test();
    end
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {chan, harm, freq} = '0;
    {fitted, ren, addr_lvl, hold} = 4'h0;
    hsel = 6'h00;
    msg = 7'h00;
    bad_count = 0;
    n_compared = 0;
    cyc = 0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_chan();
    t_sum();
    t_freq();
    t_harm();
    t_clear();
    t_msg();
    end_of_test();
  end
endmodule
